//--- logic/pds_pkg.sv
// How it works
// - Select bit 1 feeds high band input
// - High band: divide by two, then counter
// - Select bit 0 feeds low band input
// - Low band swallow mode: direct counter, no prescaler
// - Low band direct mode: 12-bit divider
// - Pumps high when fast, low when slow
// - Pumps float when divided and reference pulses coincide
// - Controller clock 400 kHz, 66 percent duty
// - Serial bits timed by serial clock
// - Device shifts out up to 28 bits
`default_nettype none
package pds_pkg;

  localparam int unsigned CLK_SYS_HZ      = 20000000;
  localparam int unsigned CTRL_CLK_HZ     = 400000;
  localparam int unsigned CTRL_DUTY_PCT   = 66;
  localparam int unsigned CTRL_PERIOD_CYC = CLK_SYS_HZ / CTRL_CLK_HZ;
  localparam int unsigned CTRL_HIGH_CYC   =
    (CTRL_PERIOD_CYC * CTRL_DUTY_PCT) / 100;

  localparam int unsigned CTRL_WORD_BITS  = 36;
  localparam int unsigned READ_BITS       = 28;
  localparam int unsigned SWALLOW_MIN     = 256;
  localparam int unsigned DIRECT_MIN      = 4;
  localparam int unsigned DIRECT_BITS     = 12;
  localparam int unsigned REF_DIV_DEFAULT = 2000;

  localparam logic [15:0] DIVISOR_RESET   = 16'h0100;

  typedef struct packed {
    logic [17:0] spare;
    logic        pulseSwallowSelect;
    logic        dividerInputSelect;
    logic [15:0] divisor;
  } pds_ctrl_t;

  localparam pds_ctrl_t CTRL_RESET = '{
    spare:              18'h00000,
    pulseSwallowSelect: 1'b1,
    dividerInputSelect: 1'b1,
    divisor:            DIVISOR_RESET
  };

  // Output and enable of one three-state or open-drain pin
  typedef struct packed {
    logic level;
    logic oe;
  } pds_pin_t;

endpackage
`default_nettype wire

//--- logic/pds_pll_divider.sv
`timescale 1ns/100ps
`default_nettype none
module pds_pll_divider #(
  parameter int unsigned REF_DIV = pds_pkg::REF_DIV_DEFAULT
) (
  // System
  input  wire logic      clk_sys,
  input  wire logic      rstn,
  // Local oscillator inputs
  input  wire logic      highBandOscInput,
  input  wire logic      lowBandOscInput,
  // Serial link
  input  wire logic      serialSelect,
  input  wire logic      serialClockIn,
  input  wire logic      serialDataIn,
  output pds_pkg::pds_pin_t serialDataOut,
  // Charge pumps and controller clock
  output pds_pkg::pds_pin_t chargePumpOutA,
  output pds_pkg::pds_pin_t chargePumpOutB,
  output pds_pkg::pds_pin_t controllerClockOut
);

  // Reference counter is 17 bits wide and needs at least two states
  if (REF_DIV < 2 || REF_DIV > 65536) begin : g_badRefDiv
    $error("REF_DIV out of range");
  end

  // Serial front end
  logic                 sclkPrev_r;
  logic                 selPrev_r;
  logic                 sclkRise;
  logic                 sclkFall;
  logic                 selRise;
  logic                 selFall;
  logic [35:0]          shiftIn_r;
  logic [5:0]           bitCount_r;
  pds_pkg::pds_ctrl_t   ctrl_r;
  logic [27:0]          shiftOut_r;
  logic [4:0]           outCount_r;
  pds_pkg::pds_pin_t    dataOut_r;

  assign sclkRise = serialClockIn && !sclkPrev_r;
  assign sclkFall = !serialClockIn && sclkPrev_r;
  assign selRise  = serialSelect && !selPrev_r;
  assign selFall  = !serialSelect && selPrev_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sclkPrev_r <= 1'b0;
      selPrev_r  <= 1'b0;
    end else begin
      sclkPrev_r <= serialClockIn;
      selPrev_r  <= serialSelect;
    end
  end

  // Input shifting on serial clock rise while selected
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shiftIn_r  <= 36'h000000000;
      bitCount_r <= 6'h00;
    end else if (selRise) begin
      bitCount_r <= 6'h00;
    end else if (serialSelect && sclkRise) begin
      shiftIn_r <= {serialDataIn, shiftIn_r[35:1]};
      if (bitCount_r != 6'(pds_pkg::CTRL_WORD_BITS)) begin
        bitCount_r <= bitCount_r + 6'h01;
      end
    end
  end

  // Partial words never disturb the running settings
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= pds_pkg::CTRL_RESET;
    end else if (selFall &&
                 bitCount_r == 6'(pds_pkg::CTRL_WORD_BITS)) begin
      ctrl_r <= pds_ctrl_cast(shiftIn_r);
    end
  end

  function automatic pds_pkg::pds_ctrl_t pds_ctrl_cast(
    input logic [35:0] word
  );
    pds_ctrl_cast = word;
  endfunction

  // Phase detector state, read back by the controller
  logic upFlag_r;
  logic downFlag_r;

  // Read shifter loaded at select rise, shifts on serial clock fall
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      shiftOut_r <= 28'h0000000;
      outCount_r <= 5'h00;
    end else if (selRise) begin
      shiftOut_r <= {8'h00, upFlag_r, downFlag_r,
                     ctrl_r.pulseSwallowSelect,
                     ctrl_r.dividerInputSelect, ctrl_r.divisor};
      outCount_r <= 5'h00;
    end else if (serialSelect && sclkFall &&
                 outCount_r != 5'(pds_pkg::READ_BITS)) begin
      shiftOut_r <= {1'b0, shiftOut_r[27:1]};
      outCount_r <= outCount_r + 5'h01;
    end
  end

  // Open drain: pull low for a zero, release otherwise
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dataOut_r <= '{level: 1'b0, oe: 1'b0};
    end else begin
      dataOut_r.level <= 1'b0;
      dataOut_r.oe    <= serialSelect && !selRise &&
                         outCount_r != 5'(pds_pkg::READ_BITS) &&
                         !shiftOut_r[0];
    end
  end
  assign serialDataOut = dataOut_r;

  // Oscillator edge detection
  logic hiPrev_r;
  logic loPrev_r;
  logic prescale_r;
  logic hiEdge;
  logic loEdge;
  logic divEdge;

  assign hiEdge = highBandOscInput && !hiPrev_r;
  assign loEdge = lowBandOscInput && !loPrev_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hiPrev_r   <= 1'b0;
      loPrev_r   <= 1'b0;
      prescale_r <= 1'b0;
    end else begin
      hiPrev_r <= highBandOscInput;
      loPrev_r <= lowBandOscInput;
      if (hiEdge) begin
        prescale_r <= !prescale_r;
      end
    end
  end

  // Source mux: prescaled high band, or raw low band
  always_comb begin
    if (ctrl_r.dividerInputSelect) begin
      divEdge = hiEdge && prescale_r;
    end else begin
      divEdge = loEdge;
    end
  end

  // Divisor of zero stands for the top of the range
  function automatic logic [16:0] pds_modulus(
    input pds_pkg::pds_ctrl_t c
  );
    if (!c.dividerInputSelect && !c.pulseSwallowSelect) begin
      pds_modulus = (c.divisor[11:0] == 12'h000) ?
                    17'h01000 : {5'h00, c.divisor[11:0]};
    end else begin
      pds_modulus = (c.divisor == 16'h0000) ?
                    17'h10000 : {1'b0, c.divisor};
    end
  endfunction

  logic [16:0] divCount_r;
  logic        divPulse_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      divCount_r <= 17'h00000;
      divPulse_r <= 1'b0;
    end else begin
      divPulse_r <= 1'b0;
      if (divEdge) begin
        if (divCount_r <= 17'h00001) begin
          divCount_r <= pds_modulus(ctrl_r);
          divPulse_r <= 1'b1;
        end else begin
          divCount_r <= divCount_r - 17'h00001;
        end
      end
    end
  end

  // Reference divider from the crystal clock
  logic [16:0] refCount_r;
  logic        refPulse_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      refCount_r <= 17'h00000;
      refPulse_r <= 1'b0;
    end else if (refCount_r == 17'(REF_DIV - 1)) begin
      refCount_r <= 17'h00000;
      refPulse_r <= 1'b1;
    end else begin
      refCount_r <= refCount_r + 17'h00001;
      refPulse_r <= 1'b0;
    end
  end

  // Phase-frequency detector; coincident pulses cancel
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      upFlag_r   <= 1'b0;
      downFlag_r <= 1'b0;
    end else begin
      if ((upFlag_r || divPulse_r) && (downFlag_r || refPulse_r)) begin
        upFlag_r   <= 1'b0;
        downFlag_r <= 1'b0;
      end else begin
        upFlag_r   <= upFlag_r || divPulse_r;
        downFlag_r <= downFlag_r || refPulse_r;
      end
    end
  end

  pds_pkg::pds_pin_t pump_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pump_r <= '{level: 1'b0, oe: 1'b0};
    end else begin
      pump_r.level <= upFlag_r;
      pump_r.oe    <= upFlag_r || downFlag_r;
    end
  end
  assign chargePumpOutA = pump_r;
  assign chargePumpOutB = pump_r;

  // Controller clock runs from reset release, independent of the link
  logic [5:0]        sysCount_r;
  pds_pkg::pds_pin_t sysClk_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sysCount_r <= 6'h00;
      sysClk_r   <= '{level: 1'b0, oe: 1'b0};
    end else begin
      if (sysCount_r == 6'(pds_pkg::CTRL_PERIOD_CYC - 1)) begin
        sysCount_r <= 6'h00;
      end else begin
        sysCount_r <= sysCount_r + 6'h01;
      end
      sysClk_r.level <= 1'b0;
      sysClk_r.oe    <= sysCount_r >=
                        6'(pds_pkg::CTRL_HIGH_CYC);
    end
  end
  assign controllerClockOut = sysClk_r;

endmodule
`default_nettype wire

//--- test/pds_pll_divider_chk.sv
`timescale 1ns/100ps
`default_nettype none
module pds_pll_divider_chk (
  // System
  input wire logic              clk_sys,
  input wire logic              rstn,
  // Serial link
  input wire logic              serialSelect,
  input wire logic              serialClockIn,
  input wire pds_pkg::pds_pin_t serialDataOut,
  // Pumps and controller clock
  input wire pds_pkg::pds_pin_t chargePumpOutA,
  input wire pds_pkg::pds_pin_t chargePumpOutB,
  input wire pds_pkg::pds_pin_t controllerClockOut
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_lowPhase;
    $rose(controllerClockOut.oe) |-> ##17 $fell(controllerClockOut.oe);
  endproperty
  a_lowPhase: assert property (p_lowPhase)
    else $error("controller clock low phase length");
  property p_highPhase;
    $fell(controllerClockOut.oe) |-> ##33 $rose(controllerClockOut.oe);
  endproperty
  a_highPhase: assert property (p_highPhase)
    else $error("controller clock high phase length");
  property p_period;
    $rose(controllerClockOut.oe) |-> ##50 $rose(controllerClockOut.oe);
  endproperty
  a_period: assert property (p_period)
    else $error("controller clock period");
  property p_clkDrain;
    !controllerClockOut.level;
  endproperty
  a_clkDrain: assert property (p_clkDrain)
    else $error("controller clock drives high");
  property p_dataDrain;
    !serialDataOut.level;
  endproperty
  a_dataDrain: assert property (p_dataDrain)
    else $error("serial out drives high");
  property p_pumpsMatch;
    chargePumpOutA == chargePumpOutB;
  endproperty
  a_pumpsMatch: assert property (p_pumpsMatch)
    else $error("pump outputs differ");
  property p_release;
    !serialSelect[*3] |-> !serialDataOut.oe;
  endproperty
  a_release: assert property (p_release)
    else $error("serial out held without select");
  property p_holdBit;
    (serialSelect && serialClockIn)[*4] |-> $stable(serialDataOut.oe);
  endproperty
  a_holdBit: assert property (p_holdBit)
    else $error("serial out moved without clock fall");

  c_pumpUp: cover property (chargePumpOutA.oe && chargePumpOutA.level);
  c_pumpDown: cover property (chargePumpOutA.oe && !chargePumpOutA.level);
  c_readBit: cover property (serialDataOut.oe);
endmodule

bind pds_pll_divider pds_pll_divider_chk pds_pll_divider_chk_inst (
  .clk_sys(clk_sys), .rstn(rstn), .serialSelect(serialSelect),
  .serialClockIn(serialClockIn), .serialDataOut(serialDataOut),
  .chargePumpOutA(chargePumpOutA), .chargePumpOutB(chargePumpOutB),
  .controllerClockOut(controllerClockOut));
`default_nettype wire

//--- test/pds_ctrl_model.sv
`timescale 1ns/100ps
`default_nettype none
module pds_ctrl_model (
  // System
  input  wire logic clk_sys,
  // Serial link
  output var  logic serialSelect,
  output var  logic serialClockIn,
  output var  logic serialDataIn,
  input  wire logic serialDataWire
);
  initial begin
    serialSelect = 1'b0;
    serialClockIn = 1'b0;
    serialDataIn = 1'b0;
  end

  // LSB first; bit i is read just before the rise that sends bit i
  task automatic xfer(input logic [35:0] w, input int n, input int half,
                      output logic [27:0] rd);
    rd = '0;
    repeat (3) @(posedge clk_sys);
    serialSelect <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      serialDataIn <= w[i];
      repeat (half) @(posedge clk_sys);
      if (i < 28) rd[i] = serialDataWire;
      serialClockIn <= 1'b1;
      repeat (half) @(posedge clk_sys);
      serialClockIn <= 1'b0;
    end
    repeat (half) @(posedge clk_sys);
    serialSelect <= 1'b0;
    // Released data line must not keep its last value
    serialDataIn <= ~serialDataIn;
  endtask
endmodule
`default_nettype wire

//--- test/tb_pds_pll_divider.sv
`timescale 1ns/100ps
`default_nettype none
module tb_pds_pll_divider;
  logic              clk_sys;
  logic              rstn = 1'b0;
  logic              hiOsc = 1'b0;
  logic              loOsc = 1'b0;
  logic [1:0]        loPh = 2'h0;
  logic              sel;
  logic              sclk;
  logic              sdi;
  wire               sdoWire;
  pds_pkg::pds_pin_t sdo;
  pds_pkg::pds_pin_t pumpA;
  pds_pkg::pds_pin_t pumpB;
  pds_pkg::pds_pin_t ctlClk;
  int                failures = 0;
  int                samples_checked = 0;
  int                cycles = 0;
  int                hiCnt;
  int                loCnt;
  int                n;
  logic [27:0]       rd;
  logic [17:0]       prev;
  logic [35:0]       rstWord = pds_pkg::CTRL_RESET;
  // {pump fast, swallow, input select, divisor}; reference every 20 cycles
  logic [18:0]       rows [5] = '{19'h30006, 19'h50004, 19'h60003,
                                  19'h20004, 19'h41003};

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Pull-up on the open-drain line
  assign sdoWire = sdo.oe ? 1'b0 : 1'b1;
  // High band rises every 2 cycles, low band every 6
  always @(posedge clk_sys) begin
    hiOsc <= ~hiOsc;
    loPh <= (loPh == 2'h2) ? 2'h0 : loPh + 2'h1;
    if (loPh == 2'h2) loOsc <= ~loOsc;
  end

  pds_ctrl_model pds_ctrl_model_inst (.clk_sys(clk_sys), .serialSelect(sel),
    .serialClockIn(sclk), .serialDataIn(sdi), .serialDataWire(sdoWire));
  pds_pll_divider #(.REF_DIV(20)) pds_pll_divider_inst (.clk_sys(clk_sys),
    .rstn(rstn), .highBandOscInput(hiOsc), .lowBandOscInput(loOsc),
    .serialSelect(sel), .serialClockIn(sclk), .serialDataIn(sdi),
    .serialDataOut(sdo), .chargePumpOutA(pumpA), .chargePumpOutB(pumpB),
    .controllerClockOut(ctlClk));

  task automatic chk(input string nm, input logic [27:0] got,
                     input logic [27:0] want);
    samples_checked++;
    if (got !== want) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, want, got);
    end
  endtask
  task automatic close_out;
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic runLen(input logic v);
    n = 0;
    while (ctlClk.oe === v && n < 100) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask
  task automatic rdBack(input int half, input logic [17:0] want);
    pds_ctrl_model_inst.xfer(36'h0, 28, half, rd);
    chk("readback", {2'h0, rd[27:20], rd[17:0]}, {10'h000, want});
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    chk("resetOe", {25'h0, sdo.oe, pumpA.oe, ctlClk.oe}, 28'h0);
    rstn <= 1'b1;
    runLen(1'b0);
    runLen(1'b1);
    chk("clkLowLen", n[27:0], 28'h11);
    runLen(1'b0);
    chk("clkHighLen", n[27:0], 28'h21);
    rdBack(4, rstWord[17:0]);
    prev = rstWord[17:0];
    for (int r = 0; r < 5; r++) begin
      pds_ctrl_model_inst.xfer({18'h0, rows[r][17:0]}, 36, 4, rd);
      chk("oldCfg", {10'h0, rd[17:0]}, {10'h0, prev});
      prev = rows[r][17:0];
      rdBack(4, prev);
      repeat (200) @(posedge clk_sys);
      hiCnt = 0;
      loCnt = 0;
      repeat (400) begin
        @(posedge clk_sys);
        #1;
        hiCnt += (pumpA.oe === 1'b1 && pumpA.level === 1'b1);
        loCnt += (pumpA.oe === 1'b1 && pumpA.level === 1'b0);
      end
      chk("pumpDir", {27'h0, hiCnt > loCnt}, {27'h0, rows[r][18]});
      chk("pumpFloat", {27'h0, hiCnt + loCnt < 400}, 28'h1);
    end
    // Short word is dropped; slow clock on the read
    pds_ctrl_model_inst.xfer(36'h0, 35, 4, rd);
    rdBack(9, prev);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("midReset", {25'h0, sdo.oe, pumpB.oe, ctlClk.oe}, 28'h0);
    rstn <= 1'b1;
    rdBack(4, rstWord[17:0]);
    close_out();
  end
endmodule
`default_nettype wire
